// ### logic/usw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module usw_ctrl #(
	parameter int HOLD_CYC = usw_pkg::RST_HOLD_CYC
) (
	input  wire logic REF_CLK,          // internal reference clock
	input  wire logic RST_N,            // power-on reset, active low
	input  wire logic SUPPLY_OK,        // supply above threshold
	input  wire logic OSC_RUN,          // oscillator running
	input  wire logic OSC_IN,           // oscillator cell level
	input  wire logic EXT_RESET_N,      // external reset pin
	input  wire logic USB_CONFIGURED,   // host finished configuration
	input  wire logic USB_SUSPEND,      // link is suspended
	input  wire logic USB_BUS_RESET,    // usb bus reset seen
	input  wire logic CFG_REMOTE_WAKE,  // stored remote wakeup option
	input  wire logic CFG_PULL_DN,      // stored suspend pull-down option
	input  wire logic SEND_NOW_WAKE_N,  // send-now / wake strobe pin
	input  wire logic TX_NOT_EMPTY,     // transmit buffer holds data
	input  wire logic BULK_IN_SERVED,   // bulk IN request answered
	output logic      POWER_ON_N,       // power enable, active low
	output logic      RESUME_REQ,       // resume request pulse
	output logic      SEND_SHORT,       // flush pending for next IN
	output logic      RESET_OUT_N_O,    // reset output level
	output logic      RESET_OUT_N_OE,   // reset output drive enable
	output logic      OSC_OUT,          // oscillator output
	output logic      FIFO_PULL_DN,     // data pins weak pull-down
	output logic      STATUS_PINS_OE,   // fifo status pins drive
	output logic      STATUS_PULLUP_EN, // status pins weak pull-up
	output logic      EEPROM_PINS_OE,   // memory pins drive
	output logic      EEPROM_PULLUP_EN, // memory pins weak pull-up
	output logic      DEVICE_IN_RESET   // internal reset in progress
);
	localparam logic [usw_pkg::RST_CNT_W-1:0] HOLD_M1 =
		usw_pkg::RST_CNT_W'(HOLD_CYC - 1);

	if (HOLD_CYC < 1 || HOLD_CYC >= (1 << usw_pkg::RST_CNT_W)) begin : g_chk
		$error("HOLD_CYC out of counter range");
	end

	usw_pkg::usw_top_t st_r;
	usw_pkg::usw_top_t st_nxt;
	logic              strobe;
	logic              ok;
	logic              dev_rst;

	// single clock domain for suspend, wake and reset control
	usw_strobe u_strobe (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.pin_n (SEND_NOW_WAKE_N),
		.pulse (strobe)
	);

	assign ok = SUPPLY_OK & OSC_RUN;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.resume = 1'b0;
		// bus reset is deliberately not an input here
		if (!ok) begin
			st_nxt.seq = usw_pkg::SEQ_HIZ;
			st_nxt.cnt = '0;
		end else if (!EXT_RESET_N) begin
			st_nxt.seq = usw_pkg::SEQ_LOW;
			st_nxt.cnt = '0;
		end else begin
			unique case (st_r.seq)
				usw_pkg::SEQ_HIZ, usw_pkg::SEQ_LOW: begin
					if (st_r.cnt == HOLD_M1) begin
						st_nxt.seq = usw_pkg::SEQ_HIGH;
						st_nxt.cnt = '0;
					end else begin
						st_nxt.cnt = st_r.cnt + 1'b1;
					end
				end
				usw_pkg::SEQ_HIGH: begin
					st_nxt.seq = usw_pkg::SEQ_HIGH;
				end
				default: begin
					st_nxt.seq = usw_pkg::SEQ_HIZ;
					st_nxt.cnt = '0;
				end
			endcase
		end
		dev_rst = (st_nxt.seq != usw_pkg::SEQ_HIGH);

		if (dev_rst) begin
			st_nxt.configured = 1'b0;
			st_nxt.flush      = 1'b0;
		end else begin
			// configuration wins over a bus reset in the same cycle
			if (USB_CONFIGURED) begin
				st_nxt.configured = 1'b1;
			end else if (USB_BUS_RESET) begin
				st_nxt.configured = 1'b0;
			end
			if (strobe && st_r.pwr_n && USB_SUSPEND && CFG_REMOTE_WAKE) begin
				st_nxt.resume = 1'b1;
			end
			// a fresh strobe beats the clear by a served IN request
			if (strobe && !st_r.pwr_n) begin
				st_nxt.flush = TX_NOT_EMPTY;
			end else if (BULK_IN_SERVED) begin
				st_nxt.flush = 1'b0;
			end
		end
		st_nxt.pwr_n    = ~(st_nxt.configured & ~USB_SUSPEND);
		st_nxt.rst_oe   = (st_nxt.seq != usw_pkg::SEQ_HIZ);
		st_nxt.rst_o    = (st_nxt.seq == usw_pkg::SEQ_HIGH);
		st_nxt.osc      = USB_SUSPEND ? 1'b0 : OSC_IN;
		st_nxt.pull_dn  = CFG_PULL_DN & USB_SUSPEND;
		st_nxt.stat_oe  = ~dev_rst;
		st_nxt.stat_pu  = dev_rst;
		st_nxt.ee_oe    = ~dev_rst;
		st_nxt.ee_pu    = dev_rst;
		st_nxt.in_reset = dev_rst;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= usw_pkg::TOP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign POWER_ON_N       = st_r.pwr_n;
	assign RESUME_REQ       = st_r.resume;
	assign SEND_SHORT       = st_r.flush;
	assign RESET_OUT_N_O    = st_r.rst_o;
	assign RESET_OUT_N_OE   = st_r.rst_oe;
	assign OSC_OUT          = st_r.osc;
	assign FIFO_PULL_DN     = st_r.pull_dn;
	assign STATUS_PINS_OE   = st_r.stat_oe;
	assign STATUS_PULLUP_EN = st_r.stat_pu;
	assign EEPROM_PINS_OE   = st_r.ee_oe;
	assign EEPROM_PULLUP_EN = st_r.ee_pu;
	assign DEVICE_IN_RESET  = st_r.in_reset;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	a_pwr_on_cfg: assert property (
		USB_CONFIGURED && !USB_SUSPEND && ok && EXT_RESET_N
			&& st_r.seq == usw_pkg::SEQ_HIGH |=> !POWER_ON_N
	) else $error("power enable not low after configuration");

	a_pwr_off_susp: assert property (
		USB_SUSPEND |=> POWER_ON_N
	) else $error("power enable not high in suspend");

	a_resume_pulse: assert property (
		strobe && POWER_ON_N && USB_SUSPEND && CFG_REMOTE_WAKE && ok
			&& EXT_RESET_N && st_r.seq == usw_pkg::SEQ_HIGH
			|=> RESUME_REQ ##1 !RESUME_REQ
	) else $error("resume request missing or too long");

	a_resume_cause: assert property (
		RESUME_REQ |-> $past(strobe) && $past(POWER_ON_N)
	) else $error("resume request without suspended strobe");

	a_flush_set: assert property (
		strobe && !POWER_ON_N && TX_NOT_EMPTY && ok && EXT_RESET_N
			&& st_r.seq == usw_pkg::SEQ_HIGH |=> SEND_SHORT
	) else $error("send-now strobe lost");

	a_flush_empty: assert property (
		strobe && !POWER_ON_N && !TX_NOT_EMPTY |=> !SEND_SHORT
	) else $error("empty buffer strobe left request pending");

	a_rst_ext_low: assert property (
		!EXT_RESET_N && ok |=> RESET_OUT_N_OE && !RESET_OUT_N_O
	) else $error("reset output not low under external reset");

	a_rst_float: assert property (
		!ok |=> !RESET_OUT_N_OE ##0 DEVICE_IN_RESET
	) else $error("reset output driven before supply and clock");

	a_rst_hold: assert property (
		$rose(RESET_OUT_N_O) |-> $past(st_r.cnt) == HOLD_M1
			&& RESET_OUT_N_OE
	) else $error("reset output released before hold time");

	a_bus_rst_none: assert property (
		USB_BUS_RESET && ok && EXT_RESET_N
			&& st_r.seq == usw_pkg::SEQ_HIGH |=> RESET_OUT_N_O
	) else $error("bus reset disturbed reset output");

	a_osc_quiet: assert property (
		USB_SUSPEND [*2] |-> !OSC_OUT
	) else $error("oscillator output toggles in suspend");

	a_pull_dn_susp: assert property (
		CFG_PULL_DN && USB_SUSPEND |=> FIFO_PULL_DN
	) else $error("data pins not pulled down in suspend");

	a_stat_tri: assert property (
		!RESET_OUT_N_O |-> !STATUS_PINS_OE && STATUS_PULLUP_EN
	) else $error("status pins driven during reset");

	a_ee_tri: assert property (
		!RESET_OUT_N_O |-> !EEPROM_PINS_OE && EEPROM_PULLUP_EN
	) else $error("memory pins driven during reset");
endmodule : usw_ctrl
`default_nettype wire

// ### logic/usw_pkg.sv
`default_nettype none
package usw_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int RST_HOLD_MS   = 5;
	// least hold, so round the cycle count up
	localparam int RST_HOLD_CYC  =
		(RST_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W     = 21;

	typedef enum logic [2:0] {
		SEQ_HIZ  = 3'b001,
		SEQ_LOW  = 3'b010,
		SEQ_HIGH = 3'b100
	} usw_seq_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic low_seen;
		logic pulse;
	} usw_strb_t;

	localparam usw_strb_t STRB_RST = '{
		s1: 1'b1, s2: 1'b1, low_seen: 1'b0, pulse: 1'b0};

	typedef struct packed {
		usw_seq_t               seq;
		logic [RST_CNT_W-1:0]   cnt;
		logic                   configured;
		logic                   pwr_n;
		logic                   resume;
		logic                   flush;
		logic                   rst_o;
		logic                   rst_oe;
		logic                   osc;
		logic                   pull_dn;
		logic                   stat_oe;
		logic                   stat_pu;
		logic                   ee_oe;
		logic                   ee_pu;
		logic                   in_reset;
	} usw_top_t;

	localparam usw_top_t TOP_RST = '{
		seq: SEQ_HIZ, cnt: 21'h000000, configured: 1'b0, pwr_n: 1'b1,
		resume: 1'b0, flush: 1'b0, rst_o: 1'b0, rst_oe: 1'b0,
		osc: 1'b0, pull_dn: 1'b0, stat_oe: 1'b0, stat_pu: 1'b1,
		ee_oe: 1'b0, ee_pu: 1'b1, in_reset: 1'b1};
endpackage : usw_pkg
`default_nettype wire

// ### logic/usw_strobe.sv
`timescale 1ns/100ps
`default_nettype none
module usw_strobe (
	input  wire logic clk,     // internal clock
	input  wire logic rst_n,   // async reset, active low
	input  wire logic pin_n,   // raw strobe pin, active low
	output logic      pulse    // one cycle per low-then-release
);
	usw_pkg::usw_strb_t st_r;
	usw_pkg::usw_strb_t st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.s1    = pin_n;
		st_nxt.s2    = st_r.s1;
		st_nxt.pulse = 1'b0;
		// event fires on release so a held-low pin counts once
		if (!st_r.s2) begin
			st_nxt.low_seen = 1'b1;
		end else if (st_r.low_seen) begin
			st_nxt.low_seen = 1'b0;
			st_nxt.pulse    = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= usw_pkg::STRB_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse = st_r.pulse;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_strobe_single: assert property (
		pulse |=> !pulse
	) else $error("strobe pulse longer than one cycle");

	a_strobe_cause: assert property (
		pulse |-> $past(st_r.low_seen) && $past(st_r.s2)
	) else $error("strobe pulse without low then release");
endmodule : usw_strobe
`default_nettype wire

// ### tb/usw_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module usw_host_model (
	input  wire logic clk,        // reference clock
	input  wire logic rst_n,      // reset, active low
	input  wire logic slow,       // answer the IN poll late
	input  wire logic send_short, // flush pending in device
	output logic      served      // bulk IN answered, one cycle
);
	// board keeps the test input grounded, no port here
	int wait_c;
	initial served = 1'b0;
	// one assignment per edge, so the pulse never glitches within a step
	always @(posedge clk) begin
		#1;
		if (!rst_n || !send_short) wait_c = 0;
		else wait_c = wait_c + 1;
		served = rst_n && send_short && (wait_c == (slow ? 20 : 1));
	end
endmodule : usw_host_model
`default_nettype wire

// ### tb/tb_usw_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_usw_ctrl;
	localparam int H = 8;
	logic clk = 1'b0, rst_n = 1'b0, sup = 1'b1, orun = 1'b1, osc_i = 1'b0;
	logic ext_n = 1'b1, cfg = 1'b0, susp = 1'b0, busr = 1'b0, rwk = 1'b0;
	logic pdn = 1'b0, sn_n = 1'b1, txne = 1'b0, slow = 1'b0, served;
	logic pwr_n, res, ssh, ro, roe, osc_o, fpd, soe, spu, eoe, epu, inrst;
	logic [7:0] exp_q[$];
	logic pwr_p = 1'b1, ss_p = 1'b0;
	int err_count = 0, samples_checked = 0, seed = 30885, n;
	always #2 clk = ~clk;
	always @(posedge clk) #1 osc_i <= 1'($random(seed));
	usw_ctrl #(.HOLD_CYC(H)) u_dut (
		.REF_CLK(clk), .RST_N(rst_n), .SUPPLY_OK(sup), .OSC_RUN(orun),
		.OSC_IN(osc_i), .EXT_RESET_N(ext_n), .USB_CONFIGURED(cfg),
		.USB_SUSPEND(susp), .USB_BUS_RESET(busr), .CFG_REMOTE_WAKE(rwk),
		.CFG_PULL_DN(pdn), .SEND_NOW_WAKE_N(sn_n), .TX_NOT_EMPTY(txne),
		.BULK_IN_SERVED(served), .POWER_ON_N(pwr_n), .RESUME_REQ(res),
		.SEND_SHORT(ssh), .RESET_OUT_N_O(ro), .RESET_OUT_N_OE(roe),
		.OSC_OUT(osc_o), .FIFO_PULL_DN(fpd), .STATUS_PINS_OE(soe),
		.STATUS_PULLUP_EN(spu), .EEPROM_PINS_OE(eoe),
		.EEPROM_PULLUP_EN(epu), .DEVICE_IN_RESET(inrst));
	usw_host_model u_host (.clk(clk), .rst_n(rst_n), .slow(slow),
		.send_short(ssh), .served(served));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic take(input logic [7:0] got);
		if (exp_q.size() == 0) chk(got, 8'hff);
		else chk(got, exp_q.pop_front());
	endtask : take
	task automatic summarize;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic strobe(input int k);
		sn_n = 1'b0;
		tick(k);
		sn_n = 1'b1;
		tick(8);
	endtask : strobe
	// sampled before the drivers move, so inputs still show the edge values
	always @(posedge clk) begin
		#0.5;
		if (rst_n) begin
			chk({7'h0, osc_o}, {7'h0, osc_i & ~susp});
			chk({7'h0, fpd}, {7'h0, pdn & susp});
			if (res === 1'b1) take(8'h01);
			if (ssh !== ss_p && ssh === 1'b1) take(8'h02);
			if (pwr_n !== pwr_p) take({7'h08, pwr_n});
		end
		ss_p = ssh;
		pwr_p = pwr_n;
	end
	initial begin
		tick(12);
		rst_n = 1'b1;
		pdn = 1'($random(seed));
		n = 0;
		while (inrst !== 1'b0 && n < 100) begin
			chk({2'h0, ro, roe, soe, spu, eoe, epu}, 8'h05);
			tick();
			n++;
		end
		chk(n[7:0], 8'(H));
		chk({2'h0, ro, roe, soe, spu, eoe, epu}, 8'h3a);
		busr = 1'b1;
		tick();
		busr = 1'b0;
		tick(3);
		chk({6'h0, ro, roe}, 8'h03);
		ext_n = 1'b0;
		tick(2);
		chk({5'h0, ro, roe, inrst}, 8'h03);
		ext_n = 1'b1;
		n = 0;
		while (ro !== 1'b1 && n < 100) begin
			chk({7'h0, roe}, 8'h01);
			tick();
			n++;
		end
		chk(n[7:0], 8'(H));
		// supply or oscillator loss floats the output and restarts the hold
		sup = 1'b0;
		tick(2);
		chk({5'h0, ro, roe, inrst}, 8'h01);
		sup = 1'b1;
		orun = 1'b0;
		tick(2);
		chk({5'h0, ro, roe, inrst}, 8'h01);
		orun = 1'b1;
		n = 0;
		while (inrst !== 1'b0 && n < 100) begin
			chk({6'h0, ro, roe}, 8'h00);
			tick();
			n++;
		end
		chk(n[7:0], 8'(H));
		chk({6'h0, ro, roe}, 8'h03);
		pdn = 1'b0;
		exp_q.push_back(8'h10);
		cfg = 1'b1;
		tick();
		cfg = 1'b0;
		tick(3);
		txne = 1'b1;
		exp_q.push_back(8'h02);
		strobe(1);
		// held low for several cycles still counts once
		exp_q.push_back(8'h02);
		strobe(4);
		slow = 1'b1;
		exp_q.push_back(8'h02);
		strobe(1);
		txne = 1'b0;
		strobe(1);
		chk({7'h0, ssh}, 8'h00);
		pdn = 1'b1; // switched board power wants the pull-down
		exp_q.push_back(8'h11);
		susp = 1'b1;
		tick(3);
		strobe(1);
		rwk = 1'b1;
		exp_q.push_back(8'h01);
		strobe(1);
		exp_q.push_back(8'h10);
		susp = 1'b0;
		tick(4);
		chk(8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule : tb_usw_ctrl
`default_nettype wire
